//--- verilog/scl_loader.sv
// eeprom config loader and global control register bank of the switch
// Notes on behaviour
// [RL1] no eeprom answer: start switching with defaults and strap values
// [RL2] after reset release read registers 0 to 109 from the eeprom
// [RL3] whole load finishes within 15 ms of reset release
// [RL4] byte 0 and byte 1 high nibble must match identity, else ignore rest
// [RL5] identity ok: eeprom values overwrite register defaults
// [RL6] system keeps power-down input deasserted while board reset is held
// [RL7] phy management port reaches only standard phy registers, not this bank
// [RL8] identity 0x00-0x01, globals 0x02-0x0b, ports at 0x10, dscp 0x60, mac 0x68
// [RL9] tagged user priority >= base priority (reset 4) classifies high
// [RL10] phy-mode mii enable cleared: all mii outputs tri-stated
// [RL11] buffer share set lets ports borrow; cleared limits each to one fifth
// [RL12] compliance drop mode picks which pause-type frames get dropped
// [RL13] link-change aging: link loss triggers one fast age pass
// [RL14] pass-all-frames forwards every frame including bad ones
// [RL15] two bits suppress tx or rx pause regardless of autonegotiation
// [RL16] length check drops frames with length below 1500 not matching payload
// [RL17] aging enable bit and fast-age bit steer address aging
// [RL18] aggressive backoff bit selects shorter half-duplex backoff
// [RL19] two-bit egress scheduling field picks strict or ratio service
// [RL20] mirror match bit: both ports monitored versus either
// [RL21] switch mii settings: backpressure, half duplex, flow control, 10 mbps, null vid
// [RL22] 11-bit broadcast storm limit, default 0x4a, in 64-byte blocks
// [RL23] sequential i2c reads from byte address zero
`timescale 1ns/1ps
`include "scl_defs.svh"
module scl_loader
    import scl_pkg::*;
#(
    parameter int LOAD_CYCLES = `SCL_LOAD_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       sda_in,
    input  wire logic [7:0] strap_in,
    output logic            scl_oe_out,
    output logic            sda_oe_out,
    output logic            load_done_out,
    output logic            image_ok_out,
    output logic            start_switch_out,
    output logic            load_timeout_out,
    output logic [2:0]      base_priority_out,
    output logic            mii_outputs_en_out,
    output logic            buffer_share_out,
    output logic            compliance_drop_mode_out,
    output logic            link_change_age_out,
    output logic            pass_all_out,
    output logic            tx_pause_off_out,
    output logic            rx_pause_off_out,
    output logic            length_check_out,
    output logic            aging_en_out,
    output logic            fast_age_out,
    output logic            aggr_backoff_out,
    output logic [1:0]      sched_policy_out,
    output logic            mirror_and_out,
    output logic [7:0]      switch_mii_cfg_out,
    output logic [10:0]     storm_limit_out,
    output logic [7:0]      factory_a_out,
    output logic [7:0]      factory_b_out,
    output logic [7:0]      factory_c_out,
    output logic            phy_ps_disable_out
);
    // strap_in bits: 0 mii enable, 1 pause off, 2 aging, 3 aggressive backoff,
    // 4 mii half, 5 mii flow control, 6 mii 10bt, 7 unused
    // identity of this part, values arbitrary
    localparam logic [7:0] FAMILY_CODE = 8'h5a;
    localparam logic [3:0] CHIP_CODE   = 4'h3;

    typedef enum logic [3:0] {
        ST_STRAP, ST_START, ST_DEVW, ST_ADDR, ST_RSTART, ST_DEVR,
        ST_READ, ST_STOP, ST_DONE
    } scl_st_t;

    logic       rs1_r, rst_n;
    logic [7:0] strap_s;
    logic       sda_s;    // data line after two flops
    logic       id_match; // both identity fields agree
    logic       tmo_hit;  // budget runs out this cycle
    logic       fin_ev;   // load ends this cycle
    scl_st_t    st_r;
    logic       go_r;
    scl_op_t    op_r;
    logic [7:0] wd_r;
    logic       nack_r;
    logic       bdone;
    logic [7:0] rdata;
    logic       ack_ok;
    logic       scl_oe, sda_oe;
    logic [6:0] idx_r;
    logic       fail_r;
    logic       id_ok_r;
    logic [7:0] img_r [0:11];
    logic [23:0] tcnt_r;

    // reset release through two flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    scl_strap_sync #(.WIDTH(8)) u_sync (
        .clk_in  (clk_in),
        .rst_n_in(rst_n),
        .d_in    (strap_in),
        .q_out   (strap_s)
    );

    scl_strap_sync #(.WIDTH(1)) u_sda_sync (
        .clk_in  (clk_in),
        .rst_n_in(rst_n),
        .d_in    (sda_in),
        .q_out   (sda_s)
    );

    scl_i2c_byte u_i2c (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n),
        .go_in     (go_r),
        .op_in     (op_r),
        .wdata_in  (wd_r),
        .nack_in   (nack_r),
        .sda_in    (sda_s),
        .done_out  (bdone),
        .rdata_out (rdata),
        .ack_ok_out(ack_ok),
        .scl_oe_out(scl_oe),
        .sda_oe_out(sda_oe)
    );

    // load ends at the stop or when the budget runs out
    assign tmo_hit  = (tcnt_r == 24'(LOAD_CYCLES - 2)) && (st_r != ST_DONE); // [RL3]
    assign fin_ev   = tmo_hit || (st_r == ST_STOP && bdone);
    assign id_match = (img_r[0] == FAMILY_CODE) && (rdata[7:4] == CHIP_CODE); // [RL4]

    // load timer; a load still busy at the limit is abandoned
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tcnt_r <= 24'h000000;
            load_timeout_out <= 1'b0;
        end else if (st_r != ST_DONE) begin
            tcnt_r <= tcnt_r + 24'h000001;
            if (tmo_hit) begin
                load_timeout_out <= 1'b1; // [RL3]
            end
        end
    end

    // load sequencer: address write then sequential read from byte zero
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_STRAP;
            go_r <= 1'b0;
            op_r <= SCL_OP_STOP;
            wd_r <= 8'h00;
            nack_r <= 1'b0;
            idx_r <= 7'h00;
            fail_r <= 1'b0;
            id_ok_r <= 1'b0;
        end else begin
            go_r <= 1'b0;
            if (tmo_hit) begin
                st_r <= ST_DONE; // [RL3]
            end else begin
                case (st_r)
                    ST_STRAP: if (tcnt_r == 24'h000002) begin // straps settled
                        st_r <= ST_START; // [RL2]
                        go_r <= 1'b1;
                        op_r <= SCL_OP_START;
                    end
                    ST_START: if (bdone) begin
                        st_r <= ST_DEVW;
                        go_r <= 1'b1;
                        op_r <= SCL_OP_WRITE;
                        wd_r <= {`SCL_EE_ADDR, 1'b0};
                    end
                    ST_DEVW: if (bdone) begin
                        if (ack_ok) begin
                            st_r <= ST_ADDR; // [RL23]
                            go_r <= 1'b1;
                            wd_r <= 8'h00;
                        end else begin
                            fail_r <= 1'b1; // [RL1]
                            st_r <= ST_STOP;
                            go_r <= 1'b1;
                            op_r <= SCL_OP_STOP;
                        end
                    end
                    ST_ADDR: if (bdone) begin
                        st_r <= ST_RSTART;
                        go_r <= 1'b1;
                        op_r <= SCL_OP_START;
                    end
                    ST_RSTART: if (bdone) begin
                        st_r <= ST_DEVR;
                        go_r <= 1'b1;
                        op_r <= SCL_OP_WRITE;
                        wd_r <= {`SCL_EE_ADDR, 1'b1};
                    end
                    ST_DEVR: if (bdone) begin
                        st_r <= ack_ok ? ST_READ : ST_STOP;
                        fail_r <= !ack_ok;
                        go_r <= 1'b1;
                        op_r <= ack_ok ? SCL_OP_READ : SCL_OP_STOP;
                        nack_r <= 1'b0;
                    end
                    ST_READ: if (bdone) begin
                        idx_r <= idx_r + 7'h01;
                        go_r <= 1'b1;
                        nack_r <= (idx_r + 7'h01 == `SCL_LAST_REG);
                        if (idx_r == `SCL_OFS_CHIP) begin
                            id_ok_r <= id_match; // [RL4]
                        end
                        if (idx_r == `SCL_OFS_CHIP && !id_match) begin
                            // an acked byte keeps the eeprom on the line: one nacked
                            // dummy read frees the bus before the stop
                            idx_r <= `SCL_LAST_REG; // [RL4]
                            nack_r <= 1'b1;
                        end else if (idx_r == `SCL_LAST_REG) begin
                            st_r <= ST_STOP; // [RL2]
                            op_r <= SCL_OP_STOP;
                        end
                    end
                    ST_STOP: if (bdone) begin
                        st_r <= ST_DONE;
                    end
                    ST_DONE: st_r <= ST_DONE;
                    default: st_r <= ST_DONE;
                endcase
            end
        end
    end

    // capture image bytes of the global bank; phy management never writes here
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 12; k++) begin
                img_r[k] <= 8'h00;
            end
        end else if (st_r == ST_READ && bdone && idx_r <= `SCL_OFS_GC9) begin
            img_r[idx_r[3:0]] <= rdata; // [RL8] [RL7]
        end
    end

    // open drain pins
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            scl_oe_out <= scl_oe;
            sda_oe_out <= sda_oe;
        end
    end

    // register bank: defaults and straps, overwritten by a valid image at load end
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            load_done_out <= 1'b0;
            image_ok_out <= 1'b0;
            start_switch_out <= 1'b0;
            base_priority_out <= `SCL_RST_BASEPRI;
            mii_outputs_en_out <= 1'b0;
            buffer_share_out <= 1'b1;
            compliance_drop_mode_out <= 1'b0;
            link_change_age_out <= 1'b0;
            pass_all_out <= 1'b0;
            tx_pause_off_out <= 1'b0;
            rx_pause_off_out <= 1'b0;
            length_check_out <= 1'b0;
            aging_en_out <= 1'b0;
            fast_age_out <= 1'b0;
            aggr_backoff_out <= 1'b0;
            sched_policy_out <= 2'h0;
            mirror_and_out <= 1'b0;
            switch_mii_cfg_out <= 8'h00;
            storm_limit_out <= {3'h0, `SCL_RST_GC5};
            factory_a_out <= `SCL_RST_GC6;
            factory_b_out <= `SCL_RST_GC7;
            factory_c_out <= `SCL_RST_GC8;
            phy_ps_disable_out <= 1'b0;
        end else if (st_r == ST_STRAP) begin
            mii_outputs_en_out <= strap_s[0]; // [RL10] [RL1]
            tx_pause_off_out <= strap_s[1];   // [RL15]
            rx_pause_off_out <= strap_s[1];
            aging_en_out <= strap_s[2];       // [RL17]
            aggr_backoff_out <= strap_s[3];   // [RL18]
            switch_mii_cfg_out <= {1'b0, strap_s[4], strap_s[5], strap_s[6], 4'h0};
        end else if (!load_done_out) begin
            if (fin_ev) begin
                load_done_out <= 1'b1;
                start_switch_out <= 1'b1; // [RL1]
                if (id_ok_r && !fail_r && !tmo_hit) begin
                    image_ok_out <= 1'b1; // [RL5]
                    base_priority_out <= img_r[2][6:4]; // [RL9]
                    mii_outputs_en_out <= img_r[2][`SCL_GC0_MIIEN]; // [RL10]
                    buffer_share_out <= img_r[2][`SCL_GC0_SHARE]; // [RL11]
                    compliance_drop_mode_out <= img_r[2][`SCL_GC0_COMPL]; // [RL12]
                    link_change_age_out <= img_r[2][`SCL_GC0_LCAGE]; // [RL13]
                    pass_all_out <= img_r[3][`SCL_GC1_PASSALL]; // [RL14]
                    tx_pause_off_out <= img_r[3][`SCL_GC1_TXFC]; // [RL15]
                    rx_pause_off_out <= img_r[3][`SCL_GC1_RXFC];
                    length_check_out <= img_r[3][`SCL_GC1_LENCHK]; // [RL16]
                    aging_en_out <= img_r[3][`SCL_GC1_AGE]; // [RL17]
                    fast_age_out <= img_r[3][`SCL_GC1_FASTAGE];
                    aggr_backoff_out <= img_r[3][`SCL_GC1_AGGR]; // [RL18]
                    sched_policy_out <= img_r[4][3:2]; // [RL19]
                    mirror_and_out <= img_r[4][`SCL_GC2_MIRAND]; // [RL20]
                    switch_mii_cfg_out <= {img_r[6][7:3], 3'h0}; // [RL21]
                    storm_limit_out <= {img_r[6][2:0], img_r[7]}; // [RL22]
                    factory_a_out <= img_r[8];
                    factory_b_out <= img_r[9];
                    factory_c_out <= img_r[10];
                    phy_ps_disable_out <= img_r[11][3];
                end
            end
        end
    end

    // load may not outlast its time budget
    chk_load_budget: assert property (@(posedge clk_in) disable iff (!rst_n)
        (tcnt_r >= 24'(LOAD_CYCLES - 1)) |-> load_done_out) // [RL3]
        else $error("config load exceeded time budget");

    // defaults stay when identity fails
    chk_bad_id_keep: assert property (@(posedge clk_in) disable iff (!rst_n)
        $rose(load_done_out) && !id_ok_r |=> !image_ok_out
        && storm_limit_out == {3'h0, `SCL_RST_GC5}) // [RL4]
        else $error("bad identity image applied");

    // valid image lands in the bank
    chk_image_apply: assert property (@(posedge clk_in) disable iff (!rst_n)
        $rose(image_ok_out) |-> base_priority_out == img_r[2][6:4]
        && storm_limit_out == {img_r[6][2:0], img_r[7]}) // [RL5]
        else $error("image not applied to bank");

    // switch starts even with no eeprom
    chk_start_noee: assert property (@(posedge clk_in) disable iff (!rst_n)
        load_done_out |-> start_switch_out) // [RL1]
        else $error("switch not started after load");

    // first address byte sent is zero
    chk_addr_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
        (st_r == ST_ADDR) |-> wd_r == 8'h00) // [RL23]
        else $error("eeprom read not from address zero");

    // reads stop at the last image byte
    chk_read_bound: assert property (@(posedge clk_in) disable iff (!rst_n)
        (st_r == ST_READ) |-> idx_r <= `SCL_LAST_REG) // [RL2]
        else $error("read past image end");

    // scheduling field never changes once the load is done
    chk_bank_src: assert property (@(posedge clk_in) disable iff (!rst_n)
        $changed(sched_policy_out) |-> $past(st_r) != ST_DONE) // [RL7]
        else $error("bank changed after load");

    // valid image needs a good identity
    chk_id_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
        image_ok_out |-> id_ok_r) // [RL4]
        else $error("image accepted without identity");
endmodule

//--- shared/scl_defs.svh
// register offsets, field positions, reset values and timing counts of the config loader
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH
`define SCL_CLK_HZ          25000000
`define SCL_LOAD_TIME_US    15000
`define SCL_LOAD_CYCLES     ((`SCL_LOAD_TIME_US / 1000) * (`SCL_CLK_HZ / 1000))
`define SCL_I2C_DIV         8'd62
`define SCL_LAST_REG        7'h6d
`define SCL_OFS_FAMILY      7'h00
`define SCL_OFS_CHIP        7'h01
`define SCL_OFS_GC0         7'h02
`define SCL_OFS_GC1         7'h03
`define SCL_OFS_GC2         7'h04
`define SCL_OFS_GC4         7'h06
`define SCL_OFS_GC5         7'h07
`define SCL_OFS_GC6         7'h08
`define SCL_OFS_GC7         7'h09
`define SCL_OFS_GC8         7'h0a
`define SCL_OFS_GC9         7'h0b
`define SCL_RST_GC2         8'h00
`define SCL_RST_GC5         8'h4a
`define SCL_RST_GC6         8'h24
`define SCL_RST_GC7         8'h28
`define SCL_RST_GC8         8'h24
`define SCL_RST_BASEPRI     3'h4
`define SCL_GC0_MIIEN       3
`define SCL_GC0_SHARE       2
`define SCL_GC0_COMPL       1
`define SCL_GC0_LCAGE       0
`define SCL_GC1_PASSALL     7
`define SCL_GC1_TXFC        5
`define SCL_GC1_RXFC        4
`define SCL_GC1_LENCHK      3
`define SCL_GC1_AGE         2
`define SCL_GC1_FASTAGE     1
`define SCL_GC1_AGGR        0
`define SCL_GC2_MIRAND      0
`define SCL_EE_ADDR         7'h50
`endif

//--- shared/scl_pkg.sv
// types shared by the config loader modules
package scl_pkg;
    typedef enum logic [1:0] {SCL_OP_START, SCL_OP_WRITE, SCL_OP_READ, SCL_OP_STOP} scl_op_t;
endpackage

//--- verilog/scl_i2c_byte.sv
// single-byte i2c master engine: start, stop, byte write, byte read
`timescale 1ns/1ps
`include "scl_defs.svh"
module scl_i2c_byte
    import scl_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       go_in,
    input  wire scl_op_t    op_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       nack_in,
    input  wire logic       sda_in,
    output logic            done_out,
    output logic [7:0]      rdata_out,
    output logic            ack_ok_out,
    output logic            scl_oe_out,
    output logic            sda_oe_out
);
    logic [7:0] div_r;
    logic       tick;
    logic [5:0] ph_r;     // quarter-bit phase counter
    logic       busy_r;
    scl_op_t    op_r;
    logic [8:0] sh_r;
    logic [5:0] last;

    // quarter-bit tick divider
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= 8'h00;
        end else if (!busy_r || div_r == `SCL_I2C_DIV) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    assign tick = busy_r && (div_r == `SCL_I2C_DIV);
    assign last = (op_r == SCL_OP_START || op_r == SCL_OP_STOP) ? 6'd3 : 6'd35;

    // bit sequencer, open drain: oe high pulls the line low
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_r <= 1'b0;
            ph_r <= 6'd0;
            op_r <= SCL_OP_STOP;
            sh_r <= 9'h000;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
            ack_ok_out <= 1'b0;
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (go_in && !busy_r) begin
                busy_r <= 1'b1;
                ph_r <= 6'd0;
                op_r <= op_in;
                sh_r <= (op_in == SCL_OP_READ) ? {8'hff, nack_in} : {wdata_in, 1'b1};
            end else if (tick) begin
                case (op_r)
                    SCL_OP_START: begin
                        scl_oe_out <= (ph_r == 6'd3);
                        sda_oe_out <= (ph_r >= 6'd1);
                    end
                    SCL_OP_STOP: begin
                        scl_oe_out <= (ph_r == 6'd0);
                        sda_oe_out <= (ph_r <= 6'd1);
                    end
                    default: begin
                        scl_oe_out <= (ph_r[1:0] == 2'd0) || (ph_r[1:0] == 2'd3);
                        if (ph_r[1:0] == 2'd0) begin
                            sda_oe_out <= !sh_r[8]; // data moves only while scl is low
                        end
                        if (ph_r[1:0] == 2'd2) begin
                            sh_r <= {sh_r[7:0], sda_in};
                        end
                    end
                endcase
                if (ph_r == last) begin
                    busy_r <= 1'b0;
                    done_out <= 1'b1;
                    rdata_out <= sh_r[8:1];
                    ack_ok_out <= !sh_r[0];
                end else begin
                    ph_r <= ph_r + 6'd1;
                end
            end
        end
    end
endmodule

//--- verilog/scl_strap_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module scl_strap_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] s1_r;
    genvar i;
    // one flop pair per bit
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_r[i] <= 1'b0;
                    q_out[i] <= 1'b0;
                end else begin
                    s1_r[i] <= d_in[i];
                    q_out[i] <= s1_r[i];
                end
            end
        end
    endgenerate
endmodule

//--- test/scl_eeprom_model.sv
// behavioural i2c eeprom: acks writes, returns bytes from a word pointer
`timescale 1ns/1ps
module scl_eeprom_model (
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       present_in,
    input  wire logic [7:0] id0_in,
    input  wire logic [7:0] id1_in,
    output logic            sda_oe_out
);
    int         bit_n = -1;
    logic [7:0] sh_r  = 8'h00;
    logic [7:0] ptr_r = 8'h00;
    logic [7:0] byte_v;
    logic       rd_r  = 1'b0;
    logic       go_r  = 1'b0;
    logic       adr_r = 1'b0;
    logic [7:0] rx_q[$];
    initial sda_oe_out = 1'b0;
    // start condition opens an address phase
    always @(negedge sda_in) if (scl_in === 1'b1) begin
        bit_n = 0;
        rd_r = 1'b0;
        go_r = 1'b0;
        adr_r = 1'b1;
    end
    // stop condition returns to idle
    always @(posedge sda_in) if (scl_in === 1'b1) bit_n = -1;
    // sample on rising clock; a master nack ends the read burst
    always @(posedge scl_in) if (bit_n >= 0) begin
        if (bit_n < 8) sh_r = {sh_r[6:0], sda_in};
        else if (rd_r && sda_in) bit_n = -2;
        bit_n = (bit_n == 8) ? 0 : bit_n + 1;
    end
    // ack and data change only while the clock is low
    always @(negedge scl_in) begin
        sda_oe_out = 1'b0;
        byte_v = (ptr_r == 8'h00) ? id0_in : (ptr_r == 8'h01) ? id1_in : ptr_r;
        if (bit_n == 8 && !rd_r) begin
            rx_q.push_back(sh_r);
            if (adr_r) go_r = sh_r[0];
            else ptr_r = sh_r;
            adr_r = 1'b0;
            sda_oe_out = present_in;
        end else if (bit_n == 8) begin
            ptr_r = ptr_r + 8'h01;
        end else if (bit_n >= 0) begin
            if (bit_n == 0 && go_r) rd_r = 1'b1;
            if (rd_r) sda_oe_out = present_in && !byte_v[7 - bit_n];
        end
    end
endmodule

//--- test/tb_top.sv
// bench: eeprom absent, identity mismatch and load budget cases
`timescale 1ns/1ps
module tb_top;
    localparam int LC = 30000;
    localparam logic [47:0] DFLT = {3'h4, 1'b1, 7'h00, 1'b0, 11'h04a, 24'h242824, 1'b0};
    logic        clk_in    = 1'b0;
    logic        arst_n_in = 1'b0;
    logic [7:0]  strap_in  = 8'h00;
    logic        present   = 1'b0;
    logic [7:0]  id0       = 8'h00;
    logic [7:0]  id1       = 8'h00;
    logic        scl_oe, sda_oe, ee_oe, done, ok, sw, tmo, mii, share, compl, lca;
    logic        pass, txo, rxo, lenc, age, fage, aggr, mir, ps;
    logic [2:0]  bpri;
    logic [1:0]  sched;
    logic [7:0]  mcfg, fa, fb, fc;
    logic [10:0] storm;
    logic [23:0] seq;
    int          fail_count   = 0;
    int          total_checks = 0;
    // open-drain lines with pull-ups
    wire logic        sda_w  = !(sda_oe | ee_oe);
    wire logic        scl_w  = !scl_oe;
    wire logic [47:0] bank_w = {bpri, share, compl, lca, pass, lenc, fage, sched, mir,
                                storm, fa, fb, fc, ps};
    wire logic [12:0] strp_w = {mii, txo, rxo, age, aggr, mcfg};
    always #20 clk_in = !clk_in;
    scl_loader #(.LOAD_CYCLES(LC)) i_scl_loader (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .sda_in(sda_w), .strap_in(strap_in),
        .scl_oe_out(scl_oe), .sda_oe_out(sda_oe), .load_done_out(done), .image_ok_out(ok),
        .start_switch_out(sw), .load_timeout_out(tmo), .base_priority_out(bpri),
        .mii_outputs_en_out(mii), .buffer_share_out(share), .compliance_drop_mode_out(compl),
        .link_change_age_out(lca), .pass_all_out(pass), .tx_pause_off_out(txo),
        .rx_pause_off_out(rxo), .length_check_out(lenc), .aging_en_out(age),
        .fast_age_out(fage), .aggr_backoff_out(aggr), .sched_policy_out(sched),
        .mirror_and_out(mir), .switch_mii_cfg_out(mcfg), .storm_limit_out(storm),
        .factory_a_out(fa), .factory_b_out(fb), .factory_c_out(fc), .phy_ps_disable_out(ps));
    scl_eeprom_model i_scl_eeprom_model (.scl_in(scl_w), .sda_in(sda_w),
        .present_in(present), .id0_in(id0), .id1_in(id1), .sda_oe_out(ee_oe));
    task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // strap pins as they should land in the bank
    function automatic logic [12:0] strap_exp(input logic [7:0] s);
        return {s[0], s[1], s[1], s[2], s[3], 1'b0, s[4], s[5], s[6], 4'h0};
    endfunction
    // pulse reset, then count cycles until the load reports completion
    task automatic run_load(output int cyc);
        i_scl_eeprom_model.rx_q.delete();
        i_scl_eeprom_model.ptr_r = 8'h00;
        @(negedge clk_in);
        arst_n_in = 1'b0; // power-down has no pin here, so it stays inactive
        repeat (5) @(negedge clk_in);
        arst_n_in = 1'b1;
        cyc = 0;
        while (done !== 1'b1 && cyc < 2 * LC) begin
            @(negedge clk_in);
            cyc++;
        end
        if (cyc >= 2 * LC) begin
            check("load_done", 1, 0);
            wrap_up();
        end
        seq = {i_scl_eeprom_model.rx_q[0], i_scl_eeprom_model.rx_q[1],
               i_scl_eeprom_model.rx_q[2]};
    endtask
    // no device answers: switching starts from defaults and straps
    task automatic t_absent();
        int cyc;
        present = 1'b0;
        strap_in = 8'h55;
        run_load(cyc);
        check("image_ok", 0, ok);
        check("start_switch", 1, sw);
        check("timeout", 0, tmo);
        check("bank", DFLT, bank_w);
        check("straps", strap_exp(strap_in), strp_w);
        check("dev_addr", 8'ha0, seq[23:16]);
    endtask
    // mismatch in either identity byte: the rest of the image is ignored
    task automatic t_bad_id();
        int cyc;
        logic [15:0] ids [2] = '{16'h5b30, 16'h5a40};
        present = 1'b1;
        strap_in = 8'h2a;
        foreach (ids[i]) begin
            {id0, id1} = ids[i];
            run_load(cyc);
            check("image_ok", 0, ok);
            check("start_switch", 1, sw);
            check("read_count", 3, i_scl_eeprom_model.ptr_r);
            check("bank", DFLT, bank_w);
            check("straps", strap_exp(strap_in), strp_w);
            check("cmd_seq", 24'ha000a1, seq);
        end
    endtask
    // valid identity but a short budget: load cut off, defaults kept
    task automatic t_budget();
        int cyc;
        {id0, id1} = 16'h5a35;
        run_load(cyc);
        check("timeout", 1, tmo);
        check("budget", 1, cyc > LC - 8 && cyc < LC + 8);
        check("image_ok", 0, ok);
        check("past_id", 1, i_scl_eeprom_model.ptr_r > 8'h02);
        check("bank", DFLT, bank_w);
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        t_absent();
        t_bad_id();
        t_budget();
        wrap_up();
    end
endmodule
